/* File: core/occ_channel.v */
// Purpose: One output compare channel with APB registers and interrupt
// Assumes: Time base counts come from logic on clk_i; fault pin is asynchronous
// Notes: Notes on behaviour follow
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "occ_regs.vh"
module occ_channel #(
  parameter W = 16
) (
  input wire clk_i,
  input wire reset_n_i,
  input wire ce_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire cpu_idle_i,
  input wire [W-1:0] timebase_two_i,
  input wire [W-1:0] timebase_three_i,
  input wire tb_two_period_i,
  input wire tb_three_period_i,
  input wire fault_n_i,
  output reg compare_output_pin_o,
  output reg irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  // Control fields are kept as separate flops, not as a packed word
  reg idle_stop_reg; // Halt in idle when set
  reg tb_sel_reg; // Time base select
  reg [2:0] mode_reg; // Compare mode
  reg pwm_fault_status_reg; // Fault latched by hardware
  reg [W-1:0] cmp_reg; // Primary compare value / PWM duty
  reg [W-1:0] sec_reg; // Secondary compare value for pulse end
  reg [`OCC_IRQ_W-1:0] ist_reg; // Sticky interrupt status
  reg [`OCC_IRQ_W-1:0] imsk_reg; // Interrupt mask, 1 enables
  reg [W-1:0] duty_reg; // Duty latched at period boundary
  reg [2:0] state_reg; // Pulse state, one-hot
  reg [2:0] state_next;
  reg out_next;
  reg [`OCC_IRQ_W-1:0] ev; // Events this cycle
  reg [31:0] rd_mux;
  reg addr_ok;
  wire fault_n_s; // Synchronised fault pin
  wire [W-1:0] count; // Selected time base count
  wire hit; // Primary match
  wire sec_hit; // Secondary match
  wire period; // Period boundary of selected time base
  wire run; // Channel clocked this cycle
  wire acc; // APB access phase
  wire wr;
  wire mode_wr; // Control register written this cycle
  wire is_pwm;
  wire fault_now;
  wire answer_due; // Setup seen and no answer given yet

  // Pulse state codes, one-hot
  // An illegal code falls back to waiting
  localparam [2:0] S_WAIT = 3'b001; // Waiting for rising match
  localparam [2:0] S_HIGH = 3'b010; // Pulse high, waiting for end match
  localparam [2:0] S_DONE = 3'b100; // Single pulse finished

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte-addressed register select
  // Used by every write decode, so one place holds the compare
  function hit_ofs;
    input [7:0] a;
    input [7:0] o;
    begin
      hit_ofs = (a == o);
    end
  endfunction

  // Pad a W-bit value into a bus word
  // Upper bits read zero whatever W is, up to the bus width
  function [31:0] widen;
    input [W-1:0] v;
    begin
      widen = 32'h00000000;
      widen[W-1:0] = v;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sub blocks
  // The fault pin is asynchronous to clk_i, so it passes two flops first;
  // the time base counts come from logic on clk_i and need no such stage
  occ_sync u_fault_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .d_i(fault_n_i),
    .q_o(fault_n_s)
  );

  // Selector and primary match are shared with the read-back of the count,
  // so software always sees the time base that the compare is using
  occ_match #(.W(W)) u_match (
    .tb_sel_i(tb_sel_reg),
    .tb_two_i(timebase_two_i),
    .tb_three_i(timebase_three_i),
    .value_i(cmp_reg),
    .count_o(count),
    .hit_o(hit)
  );

  // Secondary match ends a pulse in modes 100 and 101
  assign sec_hit = (count == sec_reg);
  // Period boundary follows the same time base as the compare
  assign period = tb_sel_reg ? tb_three_period_i : tb_two_period_i;
  // cpu_idle_i is from clk_i logic, so it is read without a synchroniser
  // Idle halt freezes the compare logic but not the bus
  assign run = ce_i & ~(idle_stop_reg & cpu_idle_i);
  assign acc = psel_i & penable_i;
  // A write lands only at the edge where ready is also high, so a stretched
  // access phase cannot write twice
  assign wr = acc & pwrite_i & pready_o;
  // Answer due one cycle after setup; also recovers a setup missed while frozen
  assign answer_due = psel_i & ~pready_o;
  assign mode_wr = wr & hit_ofs(paddr_i, `OCC_CTRL_OFS);
  assign is_pwm = mode_reg[2] & mode_reg[1];
  // Fault counts only in mode 111; mode 110 ignores the pin
  assign fault_now = (mode_reg == `OCC_M_PWMF) & ~fault_n_s;

  ////////////////////////////////////////////////////////////////////////////
  // Output and pulse state, next values
  // Every mode computes the next pin level and the events of this cycle;
  // the clocked process decides whether they are applied (run, mode write).
  // Events are raised here even when halted; the status register masks
  // them with run so a frozen channel reports nothing.
  always @* begin
    state_next = state_reg;
    out_next = compare_output_pin_o;
    ev = {`OCC_IRQ_W{1'b0}};
    case (mode_reg)
      `OCC_M_OFF: begin
        // No compare activity, pin held low
        out_next = 1'b0;
        state_next = S_WAIT;
      end
      `OCC_M_SET_HI: begin
        if (hit) begin
          out_next = 1'b1;
          ev[`OCC_IRQ_CMP] = 1'b1;
        end
      end
      `OCC_M_SET_LO: begin
        if (hit) begin
          out_next = 1'b0;
          ev[`OCC_IRQ_CMP] = 1'b1;
        end
      end
      `OCC_M_TOGGLE: begin
        if (hit) begin
          out_next = ~compare_output_pin_o;
          ev[`OCC_IRQ_CMP] = 1'b1;
        end
      end
      `OCC_M_ONE, `OCC_M_CONT: begin
        case (state_reg)
          S_WAIT: begin
            if (hit) begin
              out_next = 1'b1;
              state_next = S_HIGH;
            end
          end
          S_HIGH: begin
            if (sec_hit) begin
              out_next = 1'b0;
              ev[`OCC_IRQ_SEC] = 1'b1;
              // One pulse stops; continuous rearms
              state_next = mode_reg[0] ? S_WAIT : S_DONE;
            end
          end
          S_DONE: begin
            // Stays low until the control register is written again
            out_next = 1'b0;
          end
          default: begin
            state_next = S_WAIT;
          end
        endcase
      end
      `OCC_M_PWM, `OCC_M_PWMF: begin
        if (fault_now | pwm_fault_status_reg) begin
          // Fault parks the pin low until the fault clears
          out_next = 1'b0;
        end else if (period) begin
          out_next = (cmp_reg != {W{1'b0}});
          ev[`OCC_IRQ_CMP] = 1'b1;
        end else if (count == duty_reg) begin
          out_next = 1'b0;
        end
      end
      default: begin
        out_next = 1'b0;
      end
    endcase
    if (fault_now & ~pwm_fault_status_reg) begin
      ev[`OCC_IRQ_FLT] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel datapath and pin
  // A control write wins over the running logic in the same cycle, so the
  // initial pin level of the new mode is never overwritten by a stale event.
  // Limitation: a write while ce_i is low is lost, like every other state.
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      compare_output_pin_o <= 1'b0;
      state_reg <= S_WAIT;
      pwm_fault_status_reg <= 1'b0;
      duty_reg <= {W{1'b0}};
    end else if (mode_wr & ce_i) begin
      // New mode sets the initial pin level
      // Fault status is cleared with the new mode, still a hardware clear
      state_reg <= S_WAIT;
      pwm_fault_status_reg <= 1'b0;
      duty_reg <= cmp_reg;
      // Mode 010 starts high, the others start low
      compare_output_pin_o <= (pwdata_i[`OCC_MODE_HI:`OCC_MODE_LO] == `OCC_M_SET_LO);
    end else if (run) begin
      compare_output_pin_o <= out_next;
      state_reg <= state_next;
      if (is_pwm & period) begin
        duty_reg <= cmp_reg;
      end
      // Set by fault; cleared by hardware once the pin returns and a period starts
      // A fault in the same cycle as a period start keeps the flag set
      if (fault_now) begin
        pwm_fault_status_reg <= 1'b1;
      end else if (period | (mode_reg != `OCC_M_PWMF)) begin
        pwm_fault_status_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  // Registers keep moving while the channel is halted in idle, so software
  // can reprogram a stopped channel; only ce_i freezes them.
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idle_stop_reg <= 1'b0;
      tb_sel_reg <= 1'b0;
      mode_reg <= `OCC_M_OFF;
      cmp_reg <= {W{1'b0}};
      sec_reg <= {W{1'b0}};
      imsk_reg <= {`OCC_IRQ_W{1'b0}};
      ist_reg <= {`OCC_IRQ_W{1'b0}};
    end else if (ce_i) begin
      if (mode_wr) begin
        idle_stop_reg <= pwdata_i[`OCC_IDLE_STOP_BIT];
        tb_sel_reg <= pwdata_i[`OCC_TBSEL_BIT];
        mode_reg <= pwdata_i[`OCC_MODE_HI:`OCC_MODE_LO];
      end
      if (wr & hit_ofs(paddr_i, `OCC_CMPV_OFS)) begin
        cmp_reg <= pwdata_i[W-1:0];
      end
      if (wr & hit_ofs(paddr_i, `OCC_SEC_OFS)) begin
        sec_reg <= pwdata_i[W-1:0];
      end
      if (wr & hit_ofs(paddr_i, `OCC_IMSK_OFS)) begin
        imsk_reg <= pwdata_i[`OCC_IRQ_W-1:0];
      end
      // Events count only on cycles where the channel runs
      // Write one to clear; a new event in the same cycle wins
      if (wr & hit_ofs(paddr_i, `OCC_IST_OFS)) begin
        ist_reg <= (ist_reg & ~pwdata_i[`OCC_IRQ_W-1:0]) | (ev & {`OCC_IRQ_W{run}});
      end else begin
        ist_reg <= ist_reg | (ev & {`OCC_IRQ_W{run}});
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unused bits read zero
  // The address is decoded in the setup cycle and the word is registered,
  // trading one cycle of latency for a clean, flop-driven read bus.
  always @* begin
    rd_mux = 32'h00000000;
    addr_ok = 1'b1;
    case (paddr_i)
      `OCC_CTRL_OFS: begin
        rd_mux[`OCC_IDLE_STOP_BIT] = idle_stop_reg;
        rd_mux[`OCC_FAULT_BIT] = pwm_fault_status_reg;
        rd_mux[`OCC_TBSEL_BIT] = tb_sel_reg;
        rd_mux[`OCC_MODE_HI:`OCC_MODE_LO] = mode_reg;
      end
      `OCC_CMPV_OFS: rd_mux = widen(cmp_reg);
      `OCC_SEC_OFS: rd_mux = widen(sec_reg);
      `OCC_TB_OFS: rd_mux = widen(count);
      `OCC_IST_OFS: rd_mux[`OCC_IRQ_W-1:0] = ist_reg;
      `OCC_IMSK_OFS: rd_mux[`OCC_IRQ_W-1:0] = imsk_reg;
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: ready registered, high in the first access cycle
  // Ready, error and read data stand for exactly one cycle; the read bus
  // is zero otherwise so a late sample shows nothing stale.
  // The interrupt is registered too and lags the status by one cycle.
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      // Answer one cycle after setup
      pready_o <= answer_due;
      // Unmapped offsets are refused with an error
      pslverr_o <= answer_due & ~addr_ok;
      // Read data only for a read; writes return zero
      prdata_o <= (answer_due & ~pwrite_i) ? rd_mux : 32'h00000000;
      // Level interrupt while any unmasked status bit is set
      irq_o <= |(ist_reg & imsk_reg);
    end
  end

endmodule // occ_channel

/* File: core/occ_regs.vh */
// Purpose: Register map, field positions and reset values of the compare channel
// Assumes: 32-bit APB data, one aligned word per register
// Notes: Definitions only
`ifndef OCC_REGS_VH
`define OCC_REGS_VH

// Byte offsets
`define OCC_CTRL_OFS 8'h00
`define OCC_CMPV_OFS 8'h04
`define OCC_SEC_OFS 8'h08
`define OCC_TB_OFS 8'h0C
`define OCC_IST_OFS 8'h10
`define OCC_IMSK_OFS 8'h14

// Control register fields
`define OCC_IDLE_STOP_BIT 13
`define OCC_FAULT_BIT 4
`define OCC_TBSEL_BIT 3
`define OCC_MODE_HI 2
`define OCC_MODE_LO 0
`define OCC_CTRL_WMASK 16'h200F
`define OCC_CTRL_RST 16'h0000

// Compare mode encodings
`define OCC_M_OFF 3'h0
`define OCC_M_SET_HI 3'h1
`define OCC_M_SET_LO 3'h2
`define OCC_M_TOGGLE 3'h3
`define OCC_M_ONE 3'h4
`define OCC_M_CONT 3'h5
`define OCC_M_PWM 3'h6
`define OCC_M_PWMF 3'h7

// Interrupt status bits
`define OCC_IRQ_CMP 0
`define OCC_IRQ_SEC 1
`define OCC_IRQ_FLT 2
`define OCC_IRQ_W 3

`endif

/* File: core/occ_sync.v */
// Purpose: Two-flop synchroniser for a pin level
// Assumes: Single clock domain on the receiving side
// Notes: The first stage feeds only the second
`timescale 1ns/1ps
module occ_sync (
  input wire clk_i,
  input wire reset_n_i,
  input wire ce_i,
  input wire d_i,
  output wire q_o
);
  reg meta_reg; // First stage, read only by the second
  reg sync_reg; // Second stage, safe to use

  // Shift the pin in through two flops
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // Rest at the idle level of an active-low pin, so no false event follows reset
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
    end else if (ce_i) begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end

  assign q_o = sync_reg;
endmodule // occ_sync

/* File: core/occ_match.v */
// Purpose: Time base selector and equality compare
// Assumes: Both time base counts share this clock
// Notes: Purely combinational
`timescale 1ns/1ps
module occ_match #(
  parameter W = 16
) (
  input wire tb_sel_i,
  input wire [W-1:0] tb_two_i,
  input wire [W-1:0] tb_three_i,
  input wire [W-1:0] value_i,
  output wire [W-1:0] count_o,
  output wire hit_o
);
  // Timer three when select is set, else timer two
  assign count_o = tb_sel_i ? tb_three_i : tb_two_i;
  // Equal counts make a compare event
  assign hit_o = (count_o == value_i);
endmodule // occ_match

/* File: tb/occ_tbm.sv */
// Purpose: Model of the two time bases that feed the compare channel
// Assumes: Free-running counts on the channel clock
// Notes: Unequal periods so a wrong time base shows
`timescale 1ns/1ps
module occ_tbm #(
  parameter W = 16,
  parameter P2 = 16,
  parameter P3 = 20
) (
  input wire clk_i,
  input wire reset_n_i,
  output reg [W-1:0] two_o,
  output reg [W-1:0] three_o,
  output reg two_p_o,
  output reg three_p_o
);
  ////////////////////////////////////////////////////////////////
  // Counts wrap at their period with a one-cycle rollover pulse
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      two_o <= '0;
      three_o <= '0;
      two_p_o <= 1'b0;
      three_p_o <= 1'b0;
    end else begin
      two_o <= (two_o == W'(P2 - 1)) ? '0 : two_o + 1'b1;
      three_o <= (three_o == W'(P3 - 1)) ? '0 : three_o + 1'b1;
      two_p_o <= (two_o == W'(P2 - 1));
      three_p_o <= (three_o == W'(P3 - 1));
    end
  end
endmodule // occ_tbm

/* File: tb/occ_channel_asserts.sv */
// Purpose: Port-level checks of the compare channel
// Assumes: Control and compare are shadowed from APB writes
// Notes: Bound to every channel instance
`timescale 1ns/1ps
module occ_chk #(
  parameter W = 16
) (
  input wire clk_i,
  input wire reset_n_i,
  input wire ce_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire cpu_idle_i,
  input wire [W-1:0] timebase_two_i,
  input wire [W-1:0] timebase_three_i,
  input wire compare_output_pin_o
);
  reg [15:0] ctl_reg; // Shadow of control
  reg [W-1:0] cmp_reg; // Shadow of compare value
  wire wr = psel_i & penable_i & pwrite_i & pready_o & ce_i;
  wire cw = wr && paddr_i == 8'h00;
  wire [2:0] md = ctl_reg[2:0];
  wire [W-1:0] cnt = ctl_reg[3] ? timebase_three_i : timebase_two_i;
  // Idle only halts the channel when the stop bit asks for it
  wire run = ce_i & ~(ctl_reg[13] & cpu_idle_i);
  ////////////////////////////////////////////////////////////////
  // Shadows move on the same edge as the write
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctl_reg <= 16'h0000;
      cmp_reg <= '0;
    end else begin
      if (cw)
        ctl_reg <= pwdata_i[15:0];
      if (wr && paddr_i == 8'h04)
        cmp_reg <= pwdata_i[W-1:0];
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_setup;
    psel_i && !penable_i && ce_i;
  endsequence
  sequence s_hit;
    run && cnt == cmp_reg && !cw;
  endsequence
  a_apb_ready: assert property (s_setup |=> pready_o)
    else $error("no ready after setup");
  a_rdata_quiet: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data outside answer");
  a_err_unmapped: assert property (pready_o && paddr_i > 8'h14 |-> pslverr_o && prdata_o == 0)
    else $error("unmapped access not refused");
  a_ctrl_unused: assert property (
    pready_o && !pwrite_i && paddr_i == 8'h00 |-> prdata_o[31:14] == 0 && prdata_o[12:5] == 0)
    else $error("unused control bits set");
  a_off_quiet: assert property (md == 3'h0 && !cw |=> !compare_output_pin_o)
    else $error("output active while disabled");
  a_hit_high: assert property (s_hit ##0 md == 3'h1 |=> compare_output_pin_o)
    else $error("match did not drive high");
  a_hit_low: assert property (s_hit ##0 md == 3'h2 |=> !compare_output_pin_o)
    else $error("match did not drive low");
  a_hit_toggle: assert property (
    s_hit ##0 md == 3'h3 |=> compare_output_pin_o != $past(compare_output_pin_o))
    else $error("match did not toggle");
  a_idle_hold: assert property (!run && !cw |=> $stable(compare_output_pin_o))
    else $error("output moved while halted");
endmodule // occ_chk

bind occ_channel occ_chk #(.W(W)) u_chk (
  .clk_i(clk_i),
  .reset_n_i(reset_n_i),
  .ce_i(ce_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .pwdata_i(pwdata_i),
  .prdata_o(prdata_o),
  .pready_o(pready_o),
  .pslverr_o(pslverr_o),
  .cpu_idle_i(cpu_idle_i),
  .timebase_two_i(timebase_two_i),
  .timebase_three_i(timebase_three_i),
  .compare_output_pin_o(compare_output_pin_o)
);

/* File: tb/test_output_compare_channel_control.sv */
// Purpose: Self-checking bench of the compare channel
// Assumes: APB answers in time; the watchdog ends a hung run
// Notes: Mode rows check the pin at and after the first match
`timescale 1ns/1ps
module test_output_compare_channel_control;
  reg clk_i = 1'b0;
  reg reset_n_i = 1'b0;
  reg ce_i = 1'b1;
  reg psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  reg [7:0] paddr_i = 8'h00;
  reg [31:0] pwdata_i = 32'h0, rd;
  reg cpu_idle_i = 1'b0, fault_n_i = 1'b1, er;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o, pin, irq_o, p2, p3;
  wire [15:0] t2, t3;
  integer num_errors = 0, checks = 0, i, n;
  // Rows: control word, idle level, pin at match, pin after match
  reg [18:0] rows [0:8] = '{19'h00009, 19'h00012, 19'h00019, 19'h00059,
    19'h1000C, 19'h0000D, 19'h00000, 19'h00021, 19'h00029};
  occ_tbm u_tbm (.clk_i(clk_i), .reset_n_i(reset_n_i), .two_o(t2), .three_o(t3),
    .two_p_o(p2), .three_p_o(p3));
  occ_channel DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .cpu_idle_i(cpu_idle_i), .timebase_two_i(t2), .timebase_three_i(t3),
    .tb_two_period_i(p2), .tb_three_period_i(p3), .fault_n_i(fault_n_i),
    .compare_output_pin_o(pin), .irq_o(irq_o));
  always #10 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////
  // One APB transfer, held until ready is seen at an edge
  task apb(input reg w, input reg [7:0] a, input reg [31:0] d);
    begin
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      // Wait as long as it takes; only the watchdog ends a hung transfer
      while (pready_o !== 1'b1) begin
        @(posedge clk_i);
      end
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
    end
  endtask
  task chk(input string nm, input [31:0] s, input [31:0] e);
    begin
      checks = checks + 1;
      if (s !== e) begin
        num_errors = num_errors + 1;
        $display("MISMATCH %0s exp %h seen %h", nm, e, s);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // Watchdog: the whole run needs well under a tenth of this
  initial begin
    #200000;
    num_errors = num_errors + 1;
    print_verdict;
  end
  initial begin
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    // Reset values of every register except the live count
    for (i = 0; i < 6; i = i + 1) begin
      if (i != 3) begin
        apb(1'b0, 8'(i * 4), 32'h0);
        chk("reset", rd, 32'h0);
      end
    end
    apb(1'b1, 8'h00, 32'hFFFFFFFF);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl", rd, 32'h0000200F);
    apb(1'b0, 8'h18, 32'h0);
    chk("slverr", er, 1);
    chk("unmapped", rd, 32'h0);
    apb(1'b1, 8'h04, 32'h3);
    apb(1'b1, 8'h08, 32'hA);
    // Mode rows, mask still clear so the interrupt stays low
    for (i = 0; i < 9; i = i + 1) begin
      cpu_idle_i <= rows[i][2];
      apb(1'b1, 8'h00, {16'h0000, rows[i][18:3]});
      n = 0;
      @(posedge clk_i);
      #1;
      while ((rows[i][6] ? t3 : t2) !== 16'h0003 && n < 40) begin
        n = n + 1;
        @(posedge clk_i);
        #1;
      end
      chk("match seen", n < 40, 1);
      chk("pin at match", pin, rows[i][1]);
      @(posedge clk_i);
      #1;
      chk("pin after", pin, rows[i][0]);
      chk("irq masked", irq_o, 0);
    end
    cpu_idle_i <= 1'b0;
    ce_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    ce_i <= 1'b1;
    // Status cleared first so that only a fresh compare event can raise it
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h10, 32'h7);
    apb(1'b1, 8'h14, 32'h1);
    @(posedge clk_i);
    #1;
    chk("irq idle", irq_o, 0);
    apb(1'b1, 8'h00, 32'h1);
    repeat (40) @(posedge clk_i);
    #1;
    chk("irq", irq_o, 1);
    apb(1'b0, 8'h10, 32'h0);
    chk("status", rd[0], 1);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h10, 32'h7);
    repeat (3) @(posedge clk_i);
    #1;
    chk("irq clear", irq_o, 0);
    // Fault held active in both PWM modes
    fault_n_i <= 1'b0;
    for (i = 6; i < 8; i = i + 1) begin
      apb(1'b1, 8'h00, 32'(i));
      repeat (20) @(posedge clk_i);
      // More than a full period: PWM must pulse unless the fault parks it
      n = 0;
      repeat (24) begin
        @(posedge clk_i);
        #1;
        n = n + pin;
      end
      chk("pwm pulses", n != 0, i == 6);
      apb(1'b0, 8'h00, 32'h0);
      chk("fault flag", rd[4], i == 7);
      apb(1'b0, 8'h10, 32'h0);
      chk("fault event", rd[2], i == 7);
    end
    chk("fault pin", pin, 0);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk("fault cleared", rd[4], 0);
    fault_n_i <= 1'b1;
    // Reset in mid-run, released at an edge like the first one
    apb(1'b1, 8'h00, 32'h0000200B);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk("pin in reset", pin, 0);
    chk("irq in reset", irq_o, 0);
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl after reset", rd, 32'h0);
    print_verdict;
  end
endmodule // test_output_compare_channel_control
